// >>> core/tbm_pkg.sv
package tbm_pkg;
  // register offsets on the control port
  localparam logic [7:0] TBM_OFS_SELECT   = 8'h70;
  localparam logic [7:0] TBM_OFS_READBACK = 8'h74;
  localparam logic [7:0] TBM_OFS_CTL_A    = 8'h78;
  localparam logic [7:0] TBM_OFS_CTL_B    = 8'h7c;
  localparam logic [7:0] TBM_RST_REG      = 8'h00;

  // observe selector codes
  localparam logic [7:0] TBM_SEL_QUIET    = 8'h00;
  localparam logic [7:0] TBM_SEL_BITSYNC  = 8'h0a;
  localparam logic [7:0] TBM_SEL_PN       = 8'h0b;
  localparam logic [7:0] TBM_SEL_CAL      = 8'h0c;
  localparam logic [7:0] TBM_SEL_CORR_I   = 8'h0d;
  localparam logic [7:0] TBM_SEL_CORR_Q   = 8'h0e;
  localparam logic [7:0] TBM_SEL_CHIPERR  = 8'h0f;
  localparam logic [7:0] TBM_SEL_NCO      = 8'h10;
  localparam logic [7:0] TBM_SEL_LAG      = 8'h11;
  localparam logic [7:0] TBM_SEL_PHASE    = 8'h12;
  localparam logic [7:0] TBM_SEL_IROT     = 8'h13;
  localparam logic [7:0] TBM_SEL_QROT     = 8'h14;
  localparam logic [7:0] TBM_SEL_ADC      = 8'h15;
  localparam logic [7:0] TBM_SEL_XOR_HI   = 8'h16;
  localparam logic [7:0] TBM_SEL_XOR_LO   = 8'h17;
  localparam logic [7:0] TBM_SEL_TIMING   = 8'h18;
  localparam logic [7:0] TBM_SEL_CALACC_L = 8'h19;
  localparam logic [7:0] TBM_SEL_CALACC_H = 8'h1a;
  localparam logic [7:0] TBM_SEL_FREQACC  = 8'h1b;
  localparam logic [7:0] TBM_SEL_XOR_SLOW = 8'h1c;
  localparam logic [7:0] TBM_SEL_SQ2_HI   = 8'h1d;

  // first test register fields
  localparam int TBM_A_PN_EN      = 7;
  localparam int TBM_A_SUBMUX     = 6;
  localparam int TBM_A_HRXOR      = 5;
  localparam int TBM_A_RANDADDR   = 4;
  localparam int TBM_A_FAST_CAL   = 3;
  localparam int TBM_A_TRIM_MAN   = 2;
  localparam int TBM_A_ADC_TEST   = 1;
  localparam int TBM_A_LOOPBACK   = 0;
  // second test register fields
  localparam int TBM_B_ED_CONT    = 1;
  localparam int TBM_B_CCA_LATCH  = 0;

  // timing
  localparam longint TBM_CLK_HZ       = 100_000_000;
  localparam longint TBM_TRIM_SLOW_HZ = 1000;
  localparam longint TBM_TRIM_FAST_HZ = 22000;
  localparam longint TBM_ED_WINDOW_NS = 19000;
  localparam longint TBM_CLK_NS       = 10;
  localparam int     TBM_TRIM_CNT_W   = 17;
  localparam int     TBM_ED_CNT_W     = 12;
  localparam logic [TBM_ED_CNT_W-1:0] TBM_ED_WINDOW_CYC =
    TBM_ED_CNT_W'(TBM_ED_WINDOW_NS / TBM_CLK_NS);

  typedef struct packed {
    logic [7:0]                sel;
    logic [7:0]                ctl_a;
    logic [7:0]                ctl_b;
    logic [7:0]                bus;
    logic                      strobe;
    logic [7:0]                rdata;
    logic [TBM_TRIM_CNT_W-1:0] trim_cnt;
    logic                      trim_tick;
    logic [4:0]                trim;
    logic [11:0]               adc_pins;
    logic [2:0]                rx_i;
    logic [2:0]                rx_q;
  } tbm_main_st_t;

  typedef struct packed {
    logic [TBM_ED_CNT_W-1:0] win_cnt;
    logic                    win_open;
    logic                    rx_en_prev;
    logic                    ed;
    logic                    cca;
    logic                    snap_taken;
  } tbm_ed_st_t;
endpackage

// >>> core/tbm_ed_if.sv
`timescale 1ns/1ps
interface tbm_ed_if;
  logic ed_continuous;
  logic cca_latched;
  logic receive_enable;
  logic dwell_tick;
  logic ed_comparator;
  logic raw_clear_channel;
  logic energy_detect;
  logic clear_channel;
  modport ctl
  (
    output ed_continuous, cca_latched, receive_enable, dwell_tick,
    output ed_comparator, raw_clear_channel,
    input  energy_detect, clear_channel
  );
  modport det
  (
    input  ed_continuous, cca_latched, receive_enable, dwell_tick,
    input  ed_comparator, raw_clear_channel,
    output energy_detect, clear_channel
  );
endinterface

// >>> core/tbm_ed_ctl.sv
`timescale 1ns/1ps
module tbm_ed_ctl
  import tbm_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  tbm_ed_if.det     ed
);
  tbm_ed_st_t s_q;
  tbm_ed_st_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.rx_en_prev = ed.receive_enable;
    if (ed.receive_enable && !s_q.rx_en_prev)
    begin
      s_d.win_cnt  = TBM_ED_WINDOW_CYC;
      s_d.win_open = 1'b1;
      s_d.snap_taken = 1'b0;
    end
    else if (!ed.receive_enable)
    begin
      s_d.win_open   = 1'b0;
      s_d.snap_taken = 1'b0;
    end
    else if (s_q.win_cnt != '0)
    begin
      s_d.win_cnt = s_q.win_cnt - 1'b1;
      if (s_q.win_cnt == TBM_ED_CNT_W'(1))
        s_d.win_open = 1'b0;
    end
    if (ed.dwell_tick && (ed.ed_continuous || s_q.win_open))
      s_d.ed = ed.ed_comparator;
    if (ed.dwell_tick)
    begin
      if (!ed.cca_latched)
        s_d.cca = ed.raw_clear_channel;
      else if (!s_q.snap_taken && ed.receive_enable)
      begin
        s_d.cca        = ed.raw_clear_channel;
        s_d.snap_taken = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign ed.energy_detect = s_q.ed;
  assign ed.clear_channel = s_q.cca;
endmodule

// >>> core/tbm_test_bus_mux.sv
// Summary of operation
// - code 0Ah shows bit-sync accumulator low byte, sample clock strobe.
// - code 0Bh shows top nine fault-test noise bits on bus and strobe.
// - code 0Ch shows calibration flag, energy detect, trim disable, trim.
// - codes 0Dh/0Eh show correlator I/Q bits 8:1, sample clock strobe.
// - code 0Fh shows chip error bits 14:7, strobe held low.
// - codes 10h/11h show oscillator 19:12 and lag 18:11 accumulators.
// - codes 12h to 14h show sign-extended phase and rotation errors.
// - code 15h shows zero, I converter, Q converter bits.
// - codes 16h/17h nine XOR bits; 1Ch eight XOR bits, symbol strobe.
// - code 18h shows jump clock, jump flag, symbol clock, timing bits.
// - codes 19h to 1Bh spread nine accumulator bits over bus and strobe.
// - code 1Dh shows quality metric high byte, strobe on valid.
// - readback register returns current test bus; writes ignored.
// - first test register bits 7:4 enable four test routings.
// - fast calibration bit speeds trim clock from 1kHz to 22kHz.
// - manual trim bit takes trim from trim source register bits 4:0.
// - converter test bit drives twelve converter bits to pins.
// - loopback bit feeds transmit I/Q to receive inputs.
// - energy detect stops after 19us unless continuous bit set.
// - clear-channel output raw per dwell or latched snapshot.
// - code 00h keeps the test bus quiet at zero.
`timescale 1ns/1ps
module tbm_test_bus_mux
  import tbm_pkg::*;
#(
  parameter int TRIM_SLOW_CYC = int'(TBM_CLK_HZ / TBM_TRIM_SLOW_HZ),
  parameter int TRIM_FAST_CYC = int'(TBM_CLK_HZ / TBM_TRIM_FAST_HZ)
)
(
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  input  wire logic        i_sample_clk,
  input  wire logic        i_symbol_rate_clock,
  input  wire logic [7:0]  i_bitsync_acc,
  input  wire logic [8:0]  i_pn_top,
  input  wire logic        i_cal_full_scale,
  input  wire logic [8:0]  i_corr_i,
  input  wire logic [8:0]  i_corr_q,
  input  wire logic [14:0] i_chip_err_acc,
  input  wire logic [19:0] i_nco_acc,
  input  wire logic [18:0] i_lag_acc,
  input  wire logic [6:0]  i_phase_err,
  input  wire logic [5:0]  i_inphase_rotation_error,
  input  wire logic [5:0]  i_quadrature_rotation_error,
  input  wire logic [2:0]  i_adc_i,
  input  wire logic [2:0]  i_adc_q,
  input  wire logic [5:0]  i_adc_rssi,
  input  wire logic [8:0]  i_xor_hi,
  input  wire logic [8:0]  i_xor_lo,
  input  wire logic [7:0]  i_xor_slow,
  input  wire logic        i_jump_clock_pulse,
  input  wire logic        i_jump_count_flag,
  input  wire logic [4:0]  i_master_timing_count,
  input  wire logic [17:0] i_cal_acc,
  input  wire logic [15:0] i_freq_acc,
  input  wire logic [15:0] i_second_quality_metric,
  input  wire logic        i_sq2_valid,
  input  wire logic [4:0]  i_trim_auto,
  input  wire logic [7:0]  i_trim_source_register,
  input  wire logic [2:0]  i_tx_i,
  input  wire logic [2:0]  i_tx_q,
  input  wire logic        i_receive_enable,
  input  wire logic        i_dwell_tick,
  input  wire logic        i_ed_comparator,
  input  wire logic        i_raw_clear_channel,
  output logic      [7:0]  o_test_bus,
  output logic             o_test_strobe,
  output logic             o_pn_gen_enable,
  output logic             o_subsample_mux_alt,
  output logic             o_hr_xor_to_bus,
  output logic             o_random_addr_to_bus,
  output logic      [4:0]  o_adc_trim,
  output logic             o_trim_tick,
  output logic      [11:0] o_adc_pins,
  output logic             o_modem_disable,
  output logic      [2:0]  o_rx_i,
  output logic      [2:0]  o_rx_q,
  output logic             o_energy_detect,
  output logic             o_clear_channel
);
  localparam logic [TBM_TRIM_CNT_W-1:0] SLOW_LAST =
    TBM_TRIM_CNT_W'(TRIM_SLOW_CYC - 1);
  localparam logic [TBM_TRIM_CNT_W-1:0] FAST_LAST =
    TBM_TRIM_CNT_W'(TRIM_FAST_CYC - 1);
  localparam logic [7:0] SEL_LAST_DEFINED = TBM_SEL_SQ2_HI;

  tbm_main_st_t s_q;
  tbm_main_st_t s_d;
  tbm_ed_if     ed_bus ();

  // nine bits: low eight on the bus, top bit on the strobe
  function automatic logic [8:0] spread9(input logic [8:0] v);
    spread9 = v;
  endfunction

  // sign extension of a six- or seven-bit error to a byte
  function automatic logic [7:0] sext(input logic [6:0] v,
                                      input logic        six);
    if (six)
      sext = {{2{v[5]}}, v[5:0]};
    else
      sext = {v[6], v};
  endfunction

  assign ed_bus.ed_continuous     = s_q.ctl_b[TBM_B_ED_CONT];
  assign ed_bus.cca_latched       = s_q.ctl_b[TBM_B_CCA_LATCH];
  assign ed_bus.receive_enable    = i_receive_enable;
  assign ed_bus.dwell_tick        = i_dwell_tick;
  assign ed_bus.ed_comparator     = i_ed_comparator;
  assign ed_bus.raw_clear_channel = i_raw_clear_channel;

  tbm_ed_ctl u_ed
  (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .ed        (ed_bus.det)
  );

  always_comb
  begin
    logic [8:0] nine;
    logic [7:0] cal_byte;
    nine     = '0;
    cal_byte = '0;
    s_d      = s_q;

    // register writes; second register bits 7:2 are plain storage
    if (i_reg_wr)
    begin
      case (i_reg_addr)
        TBM_OFS_SELECT: s_d.sel   = i_reg_wdata;
        TBM_OFS_CTL_A:  s_d.ctl_a = i_reg_wdata;
        TBM_OFS_CTL_B:  s_d.ctl_b = i_reg_wdata;
        default:        s_d.sel   = s_q.sel;
      endcase
    end

    if (i_reg_rd)
    begin
      case (i_reg_addr)
        TBM_OFS_SELECT:   s_d.rdata = s_q.sel;
        TBM_OFS_READBACK: s_d.rdata = s_q.bus;
        TBM_OFS_CTL_A:    s_d.rdata = s_q.ctl_a;
        TBM_OFS_CTL_B:    s_d.rdata = s_q.ctl_b;
        default:          s_d.rdata = '0;
      endcase
    end

    s_d.trim_tick = 1'b0;
    if ((s_q.ctl_a[TBM_A_FAST_CAL] && s_q.trim_cnt >= FAST_LAST) ||
        s_q.trim_cnt >= SLOW_LAST)
    begin
      s_d.trim_cnt  = '0;
      s_d.trim_tick = 1'b1;
    end
    else
      s_d.trim_cnt = s_q.trim_cnt + 1'b1;

    if (s_q.ctl_a[TBM_A_TRIM_MAN])
      s_d.trim = i_trim_source_register[4:0];
    else if (s_q.trim_tick)
      s_d.trim = i_trim_auto;

    if (s_q.ctl_a[TBM_A_ADC_TEST])
      s_d.adc_pins = {i_adc_rssi, i_adc_i, i_adc_q};
    else
      s_d.adc_pins = '0;

    if (s_q.ctl_a[TBM_A_LOOPBACK])
    begin
      s_d.rx_i = i_tx_i;
      s_d.rx_q = i_tx_q;
    end
    else
    begin
      s_d.rx_i = i_adc_i;
      s_d.rx_q = i_adc_q;
    end

    cal_byte = {i_cal_full_scale, ed_bus.energy_detect,
                s_q.ctl_a[TBM_A_TRIM_MAN], s_q.trim};

    s_d.bus    = '0;
    s_d.strobe = 1'b0;
    case (s_q.sel)
      TBM_SEL_QUIET:
      begin
        s_d.bus    = '0;
        s_d.strobe = 1'b0;
      end
      TBM_SEL_BITSYNC:
      begin
        s_d.bus    = i_bitsync_acc;
        s_d.strobe = i_sample_clk;
      end
      TBM_SEL_PN:
        nine = spread9(i_pn_top);
      TBM_SEL_CAL:
      begin
        s_d.bus    = cal_byte;
        s_d.strobe = s_q.trim_tick;
      end
      TBM_SEL_CORR_I:
      begin
        s_d.bus    = i_corr_i[8:1];
        s_d.strobe = i_sample_clk;
      end
      TBM_SEL_CORR_Q:
      begin
        s_d.bus    = i_corr_q[8:1];
        s_d.strobe = i_sample_clk;
      end
      TBM_SEL_CHIPERR:
      begin
        s_d.bus    = i_chip_err_acc[14:7];
        s_d.strobe = 1'b0;
      end
      TBM_SEL_NCO:
      begin
        s_d.bus    = i_nco_acc[19:12];
        s_d.strobe = i_sample_clk;
      end
      TBM_SEL_LAG:
      begin
        s_d.bus    = i_lag_acc[18:11];
        s_d.strobe = i_sample_clk;
      end
      TBM_SEL_PHASE:
      begin
        s_d.bus    = sext(i_phase_err, 1'b0);
        s_d.strobe = i_sample_clk;
      end
      TBM_SEL_IROT:
      begin
        s_d.bus    = sext({1'b0, i_inphase_rotation_error}, 1'b1);
        s_d.strobe = i_sample_clk;
      end
      TBM_SEL_QROT:
      begin
        s_d.bus    = sext({1'b0, i_quadrature_rotation_error}, 1'b1);
        s_d.strobe = i_sample_clk;
      end
      TBM_SEL_ADC:
      begin
        s_d.bus    = {2'h0, i_adc_i, i_adc_q};
        s_d.strobe = i_sample_clk;
      end
      TBM_SEL_XOR_HI:
        nine = spread9(i_xor_hi);
      TBM_SEL_XOR_LO:
        nine = spread9(i_xor_lo);
      TBM_SEL_XOR_SLOW:
      begin
        s_d.bus    = i_xor_slow;
        s_d.strobe = i_symbol_rate_clock;
      end
      TBM_SEL_TIMING:
      begin
        s_d.bus    = {i_jump_clock_pulse, i_jump_count_flag,
                      i_symbol_rate_clock, i_master_timing_count};
        s_d.strobe = i_sample_clk;
      end
      TBM_SEL_CALACC_L:
        nine = spread9(i_cal_acc[8:0]);
      TBM_SEL_CALACC_H:
        nine = spread9(i_cal_acc[17:9]);
      TBM_SEL_FREQACC:
        nine = spread9(i_freq_acc[15:7]);
      TBM_SEL_SQ2_HI:
      begin
        s_d.bus    = i_second_quality_metric[15:8];
        s_d.strobe = i_sq2_valid;
      end
      default:
      begin
        s_d.bus    = '0;
        s_d.strobe = 1'b0;
      end
    endcase

    if (s_q.sel == TBM_SEL_PN || s_q.sel == TBM_SEL_XOR_HI ||
        s_q.sel == TBM_SEL_XOR_LO || s_q.sel == TBM_SEL_CALACC_L ||
        s_q.sel == TBM_SEL_CALACC_H || s_q.sel == TBM_SEL_FREQACC)
    begin
      s_d.bus    = nine[7:0];
      s_d.strobe = nine[8];
    end
    if (s_q.sel > SEL_LAST_DEFINED)
    begin
      s_d.bus    = '0;
      s_d.strobe = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s_q       <= '0;
      s_q.sel   <= TBM_RST_REG;
      s_q.ctl_a <= TBM_RST_REG;
      s_q.ctl_b <= TBM_RST_REG;
    end
    else
      s_q <= s_d;
  end

  assign o_pn_gen_enable      = s_q.ctl_a[TBM_A_PN_EN];
  assign o_subsample_mux_alt  = s_q.ctl_a[TBM_A_SUBMUX];
  assign o_hr_xor_to_bus      = s_q.ctl_a[TBM_A_HRXOR];
  assign o_random_addr_to_bus = s_q.ctl_a[TBM_A_RANDADDR];
  assign o_modem_disable      = s_q.ctl_a[TBM_A_ADC_TEST];
  assign o_reg_rdata          = s_q.rdata;
  assign o_test_bus           = s_q.bus;
  assign o_test_strobe        = s_q.strobe;
  assign o_adc_trim           = s_q.trim;
  assign o_trim_tick          = s_q.trim_tick;
  assign o_adc_pins           = s_q.adc_pins;
  assign o_rx_i               = s_q.rx_i;
  assign o_rx_q               = s_q.rx_q;
  assign o_energy_detect      = ed_bus.energy_detect;
  assign o_clear_channel      = ed_bus.clear_channel;
endmodule

// >>> verification/tbm_props.sv
`timescale 1ns/1ps
module tbm_props
  import tbm_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic [7:0]  i_reg_addr,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic        i_sample_clk,
  input wire logic [7:0]  i_bitsync_acc,
  input wire logic [8:0]  i_pn_top,
  input wire logic [14:0] i_chip_err_acc,
  input wire logic [2:0]  i_adc_i,
  input wire logic [2:0]  i_adc_q,
  input wire logic [15:0] i_second_quality_metric,
  input wire logic        i_sq2_valid,
  input wire logic [2:0]  i_tx_i,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic [7:0]  o_test_bus,
  input wire logic        o_test_strobe,
  input wire logic        o_pn_gen_enable,
  input wire logic        o_modem_disable,
  input wire logic [2:0]  o_rx_i,
  input wire logic        i_cal_full_scale,
  input wire logic [4:0]  i_trim_auto,
  input wire logic        i_receive_enable,
  input wire logic        i_dwell_tick,
  input wire logic        i_ed_comparator,
  input wire logic        i_raw_clear_channel,
  input wire logic [4:0]  o_adc_trim,
  input wire logic        o_trim_tick,
  input wire logic        o_energy_detect,
  input wire logic        o_clear_channel
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  logic [7:0] sel_q;
  logic [7:0] ctl_q;
  logic [7:0] ctlb_q;
  logic [1:0] age_q;
  logic       wr_a;
  assign wr_a = i_reg_wr && i_reg_addr == TBM_OFS_CTL_A;
  // mirror of selector and both control registers
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sel_q <= 8'h00;
      ctl_q <= 8'h00;
      ctlb_q <= 8'h00;
      age_q <= 2'h3;
    end
    else
    begin
      if (i_reg_wr && i_reg_addr == TBM_OFS_SELECT)
        sel_q <= i_reg_wdata;
      if (wr_a)
        ctl_q <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == TBM_OFS_CTL_B)
        ctlb_q <= i_reg_wdata;
      age_q <= wr_a ? 2'h0 : (age_q == 2'h3 ? age_q : age_q + 2'h1);
    end
  end
  property p_quiet;
    (sel_q == TBM_SEL_QUIET || sel_q > 8'h1d)
      |=> o_test_bus == 8'h00 && !o_test_strobe;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("test bus not quiet");
  property p_bitsync;
    sel_q == TBM_SEL_BITSYNC |=> o_test_bus == $past(i_bitsync_acc)
      && o_test_strobe == $past(i_sample_clk);
  endproperty
  a_bitsync: assert property (p_bitsync)
    else $error("bit sync view wrong");
  property p_pn;
    sel_q == TBM_SEL_PN |=> {o_test_strobe, o_test_bus} == $past(i_pn_top);
  endproperty
  a_pn: assert property (p_pn)
    else $error("noise view wrong");
  property p_chip;
    sel_q == TBM_SEL_CHIPERR
      |=> o_test_bus == 8'($past(i_chip_err_acc) >> 7) && !o_test_strobe;
  endproperty
  a_chip: assert property (p_chip)
    else $error("chip error view wrong");
  property p_adc;
    sel_q == TBM_SEL_ADC
      |=> o_test_bus == {2'b00, $past(i_adc_i), $past(i_adc_q)};
  endproperty
  a_adc: assert property (p_adc)
    else $error("converter view wrong");
  property p_sq2;
    sel_q == TBM_SEL_SQ2_HI
      |=> o_test_bus == 8'($past(i_second_quality_metric) >> 8)
      && o_test_strobe == $past(i_sq2_valid);
  endproperty
  a_sq2: assert property (p_sq2)
    else $error("quality view wrong");
  property p_rdback;
    i_reg_rd && i_reg_addr == TBM_OFS_READBACK
      |=> o_reg_rdata == $past(o_test_bus);
  endproperty
  a_rdback: assert property (p_rdback)
    else $error("monitor read wrong");
  property p_ctl;
    age_q != 2'h0
      |-> o_pn_gen_enable == ctl_q[7] && o_modem_disable == ctl_q[1];
  endproperty
  a_ctl: assert property (p_ctl)
    else $error("test control level wrong");
  property p_loop;
    age_q != 2'h0 && ctl_q[0] |=> o_rx_i == $past(i_tx_i);
  endproperty
  a_loop: assert property (p_loop)
    else $error("loopback path wrong");
  property p_cal;
    sel_q == TBM_SEL_CAL |=> o_test_bus == {$past(i_cal_full_scale),
      $past(o_energy_detect), $past(ctl_q[2]), $past(o_adc_trim)}
      && o_test_strobe == $past(o_trim_tick);
  endproperty
  a_cal: assert property (p_cal)
    else $error("calibration view wrong");
  property p_trim;
    !ctl_q[2] |=> o_adc_trim == ($past(o_trim_tick) ?
      $past(i_trim_auto) : $past(o_adc_trim));
  endproperty
  a_trim: assert property (p_trim)
    else $error("automatic trim wrong");
  property p_ed_upd;
    i_dwell_tick && (ctlb_q[1] || ($past(i_receive_enable)
      && !$past(i_receive_enable, 2)))
      |=> o_energy_detect == $past(i_ed_comparator);
  endproperty
  a_ed_upd: assert property (p_ed_upd)
    else $error("energy detect not updated");
  property p_ed_hold;
    (!i_dwell_tick || (!ctlb_q[1] && !$past(i_receive_enable)))
      |=> $stable(o_energy_detect);
  endproperty
  a_ed_hold: assert property (p_ed_hold)
    else $error("energy detect moved");
  property p_cca;
    i_dwell_tick && !ctlb_q[0]
      |=> o_clear_channel == $past(i_raw_clear_channel);
  endproperty
  a_cca: assert property (p_cca)
    else $error("raw clear channel wrong");
  c_pn: cover property (sel_q == TBM_SEL_PN ##1 o_test_strobe);
  c_loop: cover property (age_q != 2'h0 && ctl_q[0]);
  c_rd: cover property (i_reg_rd && i_reg_addr == TBM_OFS_READBACK);
endmodule

bind tbm_test_bus_mux tbm_props tbm_props_inst (.*);

// >>> verification/tbm_node_src.sv
`timescale 1ns/1ps
module tbm_node_src
  import tbm_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  output logic      [255:0] o_nodes
);
  logic [255:0] s_q;
  // every node moves each cycle, so a wrong slice shows
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      s_q <= {8{32'h9e3779b9}};
    else
      s_q <= {s_q[222:0], s_q[255:223] ^ s_q[32:0] ^ 33'h05a5a5a5a};
  end
  assign o_nodes = s_q;
endmodule

// >>> verification/tbm_test_bus_mux_tb.sv
`timescale 1ns/1ps
module tbm_test_bus_mux_tb;
  import tbm_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b1;
  logic        i_reg_wr = 1'b0;
  logic        i_reg_rd = 1'b0;
  logic [7:0]  i_reg_addr = 8'h00;
  logic [7:0]  i_reg_wdata = 8'h00;
  logic        i_sample_clk, i_symbol_rate_clock, i_cal_full_scale;
  logic        i_jump_clock_pulse, i_jump_count_flag, i_sq2_valid;
  logic        i_receive_enable, i_dwell_tick, i_ed_comparator;
  logic        i_raw_clear_channel, o_test_strobe, o_pn_gen_enable;
  logic        o_subsample_mux_alt, o_hr_xor_to_bus, o_random_addr_to_bus;
  logic        o_trim_tick, o_modem_disable, o_energy_detect;
  logic        o_clear_channel;
  logic [2:0]  i_adc_i, i_adc_q, i_tx_i, i_tx_q, o_rx_i, o_rx_q;
  logic [4:0]  i_master_timing_count, i_trim_auto, o_adc_trim;
  logic [5:0]  i_inphase_rotation_error, i_quadrature_rotation_error;
  logic [5:0]  i_adc_rssi;
  logic [6:0]  i_phase_err;
  logic [7:0]  i_bitsync_acc, i_xor_slow, i_trim_source_register;
  logic [7:0]  o_reg_rdata, o_test_bus, sel, d;
  logic [8:0]  i_pn_top, i_corr_i, i_corr_q, i_xor_hi, i_xor_lo, m, v, rb;
  logic [11:0] o_adc_pins;
  logic [14:0] i_chip_err_acc;
  logic [15:0] i_freq_acc, i_second_quality_metric;
  logic [17:0] i_cal_acc;
  logic [18:0] i_lag_acc;
  logic [19:0] i_nco_acc;
  logic [27:0] e;
  logic [255:0] nodes;
  int          mismatches = 0;
  int          samples_checked = 0;
  localparam logic [7:0] ADDRS [4] =
    '{TBM_OFS_SELECT, TBM_OFS_CTL_A, TBM_OFS_CTL_B, 8'h80};
  localparam logic [7:0] VALS [3] = '{8'h0a, 8'h5a, 8'h03};
  localparam logic [7:0] CTLS [2] = '{8'hf7, 8'h00};

  assign {i_sample_clk, i_symbol_rate_clock, i_bitsync_acc, i_pn_top,
          i_cal_full_scale, i_corr_i, i_corr_q, i_chip_err_acc, i_nco_acc,
          i_lag_acc, i_phase_err, i_inphase_rotation_error,
          i_quadrature_rotation_error, i_adc_i, i_adc_q, i_adc_rssi,
          i_xor_hi, i_xor_lo, i_xor_slow, i_jump_clock_pulse,
          i_jump_count_flag, i_master_timing_count, i_cal_acc, i_freq_acc,
          i_second_quality_metric, i_sq2_valid, i_trim_auto,
          i_trim_source_register, i_tx_i, i_tx_q, i_receive_enable,
          i_dwell_tick, i_ed_comparator, i_raw_clear_channel} = nodes[229:0];

  tbm_node_src tbm_node_src_inst (.i_clk, .i_reset_n, .o_nodes(nodes));
  tbm_test_bus_mux #(.TRIM_SLOW_CYC(20), .TRIM_FAST_CYC(5))
    tbm_test_bus_mux_inst (.*);

  always #5 i_clk = ~i_clk;

  function automatic logic [8:0] view(input logic [7:0] c);
    case (c)
      TBM_SEL_BITSYNC:  return {i_sample_clk, i_bitsync_acc};
      TBM_SEL_PN:       return i_pn_top;
      TBM_SEL_CAL:      return {1'b0, i_cal_full_scale, 7'h00};
      TBM_SEL_CORR_I:   return {i_sample_clk, i_corr_i[8:1]};
      TBM_SEL_CORR_Q:   return {i_sample_clk, i_corr_q[8:1]};
      TBM_SEL_CHIPERR:  return {1'b0, i_chip_err_acc[14:7]};
      TBM_SEL_NCO:      return {i_sample_clk, i_nco_acc[19:12]};
      TBM_SEL_LAG:      return {i_sample_clk, i_lag_acc[18:11]};
      TBM_SEL_PHASE:    return {i_sample_clk, 8'(signed'(i_phase_err))};
      TBM_SEL_IROT:
        return {i_sample_clk, 8'(signed'(i_inphase_rotation_error))};
      TBM_SEL_QROT:
        return {i_sample_clk, 8'(signed'(i_quadrature_rotation_error))};
      TBM_SEL_ADC:      return {i_sample_clk, 2'b00, i_adc_i, i_adc_q};
      TBM_SEL_XOR_HI:   return i_xor_hi;
      TBM_SEL_XOR_LO:   return i_xor_lo;
      TBM_SEL_TIMING:   return {i_sample_clk, i_jump_clock_pulse,
        i_jump_count_flag, i_symbol_rate_clock, i_master_timing_count};
      TBM_SEL_CALACC_L: return i_cal_acc[8:0];
      TBM_SEL_CALACC_H: return i_cal_acc[17:9];
      TBM_SEL_FREQACC:  return i_freq_acc[15:7];
      TBM_SEL_XOR_SLOW: return {i_symbol_rate_clock, i_xor_slow};
      TBM_SEL_SQ2_HI:
        return {i_sq2_valid, i_second_quality_metric[15:8]};
      default:          return 9'h000;
    endcase
  endfunction

  function automatic logic [27:0] ctl_exp(input logic [7:0] c);
    return {c[7:4], c[1], c[1] ? {i_adc_rssi, i_adc_i, i_adc_q} : 12'h000,
            c[0] ? {i_tx_i, i_tx_q} : {i_adc_i, i_adc_q},
            i_trim_source_register[4:0] & {5{c[2]}}};
  endfunction

  task automatic check(input string what, input logic [31:0] s, x);
    samples_checked++;
    if (s !== x)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, x, s);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= w;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge i_clk);
    rb = view(sel);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_clk);
    q = o_reg_rdata;
  endtask

  task automatic ticks(input logic [31:0] x);
    logic [31:0] n;
    n = 0;
    repeat (30) @(negedge i_clk);
    repeat (100)
    begin
      @(negedge i_clk);
      n = n + o_trim_tick;
    end
    check("trim ticks", n, x);
  endtask

  initial
  begin
    #100000;
    mismatches++;
    finish_test();
  end

  initial
  begin
    i_reset_n = 1'b0;
    sel = 8'h00;
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1'b1;
    foreach (ADDRS[k])
    begin
      rd(ADDRS[k], d);
      check("reset value", d, 8'h00);
    end
    foreach (VALS[k])
      wr(ADDRS[k], VALS[k]);
    wr(TBM_OFS_READBACK, 8'hff);
    foreach (VALS[k])
    begin
      rd(ADDRS[k], d);
      check("register", d, VALS[k]);
    end
    wr(TBM_OFS_CTL_A, 8'h00);
    ticks(5);
    wr(TBM_OFS_CTL_A, 8'h08);
    ticks(20);
    foreach (CTLS[k])
    begin
      wr(TBM_OFS_CTL_A, CTLS[k]);
      @(negedge i_clk);
      repeat (4)
      begin
        e = ctl_exp(CTLS[k]);
        @(negedge i_clk);
        check("test control", {o_pn_gen_enable, o_subsample_mux_alt,
          o_hr_xor_to_bus, o_random_addr_to_bus, o_modem_disable,
          o_adc_pins, o_rx_i, o_rx_q, o_adc_trim & {5{CTLS[k][2]}}},
          e);
      end
    end
    wr(TBM_OFS_CTL_B, 8'h00);
    for (int c = 0; c < 34; c++)
    begin
      sel = 8'(c);
      m = (sel == TBM_SEL_CAL) ? 9'h0a0 : 9'h1ff;
      wr(TBM_OFS_SELECT, sel);
      @(negedge i_clk);
      repeat (4)
      begin
        v = view(sel);
        @(negedge i_clk);
        check("view", {o_test_strobe, o_test_bus} & m, v & m);
      end
      rd(TBM_OFS_READBACK, d);
      check("monitor", d & m[7:0], rb[7:0] & m[7:0]);
    end
    finish_test();
  end
endmodule
